// ---- hw/rawc_pkg.sv ----
// constants shared by the clock control register block
package rawc_pkg;
  // ----------------------------------------------------------------
  // serial command port
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WR_CTRL = 8'h43;
  localparam logic [7:0] OP_RD_CTRL = 8'hC3;
  localparam logic [7:0] OP_RD_STATUS = 8'hFE;
  localparam logic [4:0] OP_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam int REG_W = 16;
  // ----------------------------------------------------------------
  // clock control register layout
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int CTRL_WATCHDOG_ENABLE_BIT_BIT = 0;
  localparam int CTRL_WF_BIT = 1;
  localparam int CTRL_AM_LO_BIT = 2;
  localparam int CTRL_AM_HI_BIT = 3;
  localparam int CTRL_OSCILLATOR_STOP_N_BIT = 4;
  localparam int CTRL_SLOW_EN_BIT = 5;
  localparam int CTRL_BYPASS_BIT = 6;
  localparam logic [15:0] CTRL_WR_MASK = 16'h007F;
  // ----------------------------------------------------------------
  // interrupt status register and alarm select codes
  // ----------------------------------------------------------------
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam int STAT_AF_BIT = 14;
  localparam logic [1:0] AM_NONE = 2'h0;
  localparam logic [1:0] AM_MIN = 2'h1;
  localparam logic [1:0] AM_HOUR = 2'h2;
  localparam logic [1:0] AM_BOTH = 2'h3;
  localparam int MIN_W = 7;
  localparam int HOUR_W = 6;
  localparam int WD_W = 16;
  localparam logic [15:0] WD_COUNT_RESET = 16'h0000;
endpackage : rawc_pkg

// ---- hw/rawc_watchdog.sv ----
// watchdog down counter clocked by the slow oscillator tick
`timescale 1ns/1ps
module rawc_watchdog (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic tick,
  input wire logic [rawc_pkg::WD_W-1:0] reload,
  output logic expire
);
  logic [rawc_pkg::WD_W-1:0] count_q;

  // ----------------------------------------------------------------
  // counter: held at reload while disabled, reloads after reaching zero
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= rawc_pkg::WD_COUNT_RESET;
    end else if (!enable) begin
      count_q <= reload;
    end else if (tick) begin
      if (count_q == '0) begin
        count_q <= reload;
      end else begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // one-cycle pulse when the count steps from one down to zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      expire <= 1'b0;
    end else begin
      expire <= enable && tick && (count_q == {{(rawc_pkg::WD_W-1){1'b0}}, 1'b1});
    end
  end
endmodule : rawc_watchdog

// ---- hw/rawc_clock_control.sv ----
// real-time clock control register with alarm and watchdog control
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module rawc_clock_control (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic osc_slow_in,
  input wire logic [rawc_pkg::MIN_W-1:0] rtc_minutes,
  input wire logic [rawc_pkg::HOUR_W-1:0] rtc_hours,
  input wire logic [rawc_pkg::MIN_W-1:0] alarm_minutes,
  input wire logic [rawc_pkg::HOUR_W-1:0] alarm_hours,
  input wire logic int_enable,
  input wire logic [rawc_pkg::WD_W-1:0] wd_reload,
  output logic int_n,
  output logic slow_clock_out_pin,
  output logic osc_run,
  output logic crystal_bypass_select,
  output logic watchdog_out_n_o,
  output logic watchdog_out_n_oe_n
);
  // ----------------------------------------------------------------
  // alarm decode
  // ----------------------------------------------------------------
  function automatic logic alarm_hit_f(
    input logic [1:0] sel,
    input logic min_chg,
    input logic hr_chg,
    input logic min_eq,
    input logic hr_eq
  );
    logic hit;
    hit = 1'b0;
    unique case (sel)
      rawc_pkg::AM_NONE: hit = 1'b0;
      rawc_pkg::AM_MIN: hit = min_chg && min_eq;
      rawc_pkg::AM_HOUR: hit = hr_chg && hr_eq;
      rawc_pkg::AM_BOTH: hit = (min_chg || hr_chg) && min_eq && hr_eq;
    endcase
    return hit;
  endfunction : alarm_hit_f

  logic sclk_q;
  logic osc_q;
  logic [4:0] bit_cnt_q;
  logic [22:0] shift_in_q;
  logic [7:0] opcode_q;
  logic [rawc_pkg::REG_W-1:0] out_q;
  logic [rawc_pkg::REG_W-1:0] ctrl_q;
  logic alarm_flag_q;
  logic [rawc_pkg::MIN_W-1:0] min_prev_q;
  logic [rawc_pkg::HOUR_W-1:0] hr_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] opcode_next;
  logic opcode_done;
  logic data_done;
  logic status_rd;
  logic [rawc_pkg::REG_W-1:0] wr_data;
  logic [rawc_pkg::REG_W-1:0] status_word;
  logic slow_tick;
  logic wd_expire;
  logic alarm_hit;
  logic wf_next;

  // ----------------------------------------------------------------
  // serial command port: opcode then 16 data bits, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk;
      osc_q <= osc_slow_in;
    end
  end

  assign sclk_rise = !spi_cs_n && spi_sclk && !sclk_q;
  assign sclk_fall = !spi_cs_n && !spi_sclk && sclk_q;
  assign opcode_next = {shift_in_q[6:0], spi_mosi};
  assign opcode_done = sclk_rise && (bit_cnt_q == rawc_pkg::OP_BITS - 5'h01);
  assign data_done = sclk_rise && (bit_cnt_q == rawc_pkg::FRAME_BITS - 5'h01) &&
                     (opcode_q == rawc_pkg::OP_WR_CTRL);
  assign status_rd = opcode_done && (opcode_next == rawc_pkg::OP_RD_STATUS);
  assign wr_data = {shift_in_q[14:0], spi_mosi};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_q <= 5'h00;
    end else if (spi_cs_n) begin
      bit_cnt_q <= 5'h00;
    end else if (sclk_rise && bit_cnt_q != rawc_pkg::FRAME_BITS) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shift_in_q <= 23'h000000;
    end else if (sclk_rise) begin
      shift_in_q <= {shift_in_q[21:0], spi_mosi};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      opcode_q <= 8'h00;
    end else if (spi_cs_n) begin
      opcode_q <= 8'h00;
    end else if (opcode_done) begin
      opcode_q <= opcode_next;
    end
  end

  // ----------------------------------------------------------------
  // read data: loaded at the end of the opcode, shifted on falling edges
  // ----------------------------------------------------------------
  always_comb begin
    status_word = rawc_pkg::STATUS_RESET;
    status_word[rawc_pkg::STAT_AF_BIT] = alarm_flag_q;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= 16'h0000;
    end else if (opcode_done) begin
      if (opcode_next == rawc_pkg::OP_RD_CTRL) begin
        out_q <= ctrl_q;
      end else if (opcode_next == rawc_pkg::OP_RD_STATUS) begin
        out_q <= status_word;
      end else begin
        out_q <= 16'h0000;
      end
    end else if (sclk_fall && bit_cnt_q >= rawc_pkg::OP_BITS) begin
      out_q <= {out_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      spi_miso <= 1'b0;
    end else if (spi_cs_n) begin
      spi_miso <= 1'b0;
    end else if (sclk_fall && bit_cnt_q >= rawc_pkg::OP_BITS && bit_cnt_q < rawc_pkg::FRAME_BITS) begin
      spi_miso <= out_q[15];
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // the expired flag can only be cleared by software, never set; expiry wins
  assign wf_next = (ctrl_q[rawc_pkg::CTRL_WF_BIT] && wr_data[rawc_pkg::CTRL_WF_BIT]) || wd_expire;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= rawc_pkg::CTRL_RESET;
    end else if (data_done) begin
      ctrl_q <= wr_data & rawc_pkg::CTRL_WR_MASK;
      ctrl_q[rawc_pkg::CTRL_WF_BIT] <= wf_next;
    end else if (wd_expire) begin
      ctrl_q[rawc_pkg::CTRL_WF_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // oscillator and slow clock output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      osc_run <= 1'b0;
      crystal_bypass_select <= 1'b0;
    end else begin
      osc_run <= !ctrl_q[rawc_pkg::CTRL_OSCILLATOR_STOP_N_BIT];
      crystal_bypass_select <= ctrl_q[rawc_pkg::CTRL_BYPASS_BIT];
    end
  end

  // a stopped oscillator gives no square wave and no watchdog ticks
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slow_clock_out_pin <= 1'b0;
    end else begin
      slow_clock_out_pin <= ctrl_q[rawc_pkg::CTRL_SLOW_EN_BIT] && osc_run && osc_q;
    end
  end

  assign slow_tick = osc_slow_in && !osc_q && osc_run;

  // ----------------------------------------------------------------
  // time-of-day alarm
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      min_prev_q <= '0;
      hr_prev_q <= '0;
    end else begin
      min_prev_q <= rtc_minutes;
      hr_prev_q <= rtc_hours;
    end
  end

  // only a change of the clock value counts, so a standing match fires once
  assign alarm_hit = alarm_hit_f(ctrl_q[rawc_pkg::CTRL_AM_HI_BIT:rawc_pkg::CTRL_AM_LO_BIT],
                                 rtc_minutes != min_prev_q, rtc_hours != hr_prev_q,
                                 rtc_minutes == alarm_minutes, rtc_hours == alarm_hours);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      alarm_flag_q <= 1'b0;
    end else if (alarm_hit) begin
      alarm_flag_q <= 1'b1;
    end else if (status_rd) begin
      alarm_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !(alarm_flag_q && int_enable);
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  rawc_watchdog u_watchdog (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(ctrl_q[rawc_pkg::CTRL_WATCHDOG_ENABLE_BIT_BIT]),
    .tick(slow_tick),
    .reload(wd_reload),
    .expire(wd_expire)
  );

  assign watchdog_out_n_o = 1'b0;

  // open drain: only ever pulls low, floats otherwise
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_out_n_oe_n <= 1'b1;
    end else begin
      watchdog_out_n_oe_n <= !(ctrl_q[rawc_pkg::CTRL_WF_BIT] && ctrl_q[rawc_pkg::CTRL_WATCHDOG_ENABLE_BIT_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_value: assert property (@(posedge core_clk) $rose(resetn) |-> ctrl_q == rawc_pkg::CTRL_RESET)
    else $error("control register not zero after reset");
  a_slow_out_off: assert property (@(posedge core_clk) disable iff (!resetn)
    !ctrl_q[rawc_pkg::CTRL_SLOW_EN_BIT] |=> !slow_clock_out_pin)
    else $error("slow clock out active while disabled");
  a_osc_follows_bit: assert property (@(posedge core_clk) disable iff (!resetn)
    1'b1 |=> osc_run == !$past(ctrl_q[rawc_pkg::CTRL_OSCILLATOR_STOP_N_BIT]))
    else $error("oscillator run does not follow stop bit");
  a_alarm_none: assert property (@(posedge core_clk) disable iff (!resetn)
    ctrl_q[rawc_pkg::CTRL_AM_HI_BIT:rawc_pkg::CTRL_AM_LO_BIT] == rawc_pkg::AM_NONE |-> !alarm_hit)
    else $error("alarm fired with no alarm selected");
  a_alarm_minutes: assert property (@(posedge core_clk) disable iff (!resetn)
    ctrl_q[3:2] == rawc_pkg::AM_MIN && rtc_minutes != min_prev_q && rtc_minutes == alarm_minutes |-> alarm_hit)
    else $error("minute match missed");
  a_alarm_sets_int: assert property (@(posedge core_clk) disable iff (!resetn)
    alarm_hit && int_enable ##1 int_enable |=> !int_n)
    else $error("alarm did not assert interrupt");
  a_int_held: assert property (@(posedge core_clk) disable iff (!resetn)
    alarm_flag_q && !status_rd |=> alarm_flag_q)
    else $error("alarm flag dropped without status read");
  a_wf_sets: assert property (@(posedge core_clk) disable iff (!resetn)
    wd_expire |=> ctrl_q[rawc_pkg::CTRL_WF_BIT])
    else $error("expiry did not set flag");
  a_wf_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    data_done && !wr_data[rawc_pkg::CTRL_WF_BIT] && !wd_expire |=> ##1 watchdog_out_n_oe_n)
    else $error("flag clear did not release watchdog pin");
  a_wd_off_float: assert property (@(posedge core_clk) disable iff (!resetn)
    !ctrl_q[rawc_pkg::CTRL_WATCHDOG_ENABLE_BIT_BIT] |=> watchdog_out_n_oe_n)
    else $error("watchdog pin driven while disabled");
  a_status_bit: assert property (@(posedge core_clk) disable iff (!resetn)
    status_rd |=> out_q == ($past(alarm_flag_q) ? 16'h4000 : 16'h0000))
    else $error("status read word wrong");
  a_wdo_drive: assert property (@(posedge core_clk) disable iff (!resetn)
    wd_expire && ctrl_q[rawc_pkg::CTRL_WATCHDOG_ENABLE_BIT_BIT] && !data_done ##1 ctrl_q[0] |=> !watchdog_out_n_oe_n)
    else $error("watchdog pin not pulled low on expiry");
endmodule : rawc_clock_control

// ---- testbench/rawc_host.sv ----
// host model driving command frames on the serial port
`timescale 1ns/1ps
module rawc_host (
  input wire logic core_clk,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // ----------------------------------------------------------------
  // frame driver
  // ----------------------------------------------------------------
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  // one whole frame: opcode then 16 data bits, msb first
  task automatic xfer(input logic [7:0] op, input logic [15:0] wdat, output logic [15:0] rdat);
    logic [23:0] frame;
    frame = {op, wdat};
    rdat = 16'h0000;
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      spi_mosi <= frame[23 - i];
      // three low cycles so miso has settled after the fall
      repeat (3) @(posedge core_clk);
      if (i >= 8) rdat[23 - i] = spi_miso;
      spi_sclk <= 1'b1;
      repeat (2) @(posedge core_clk);
      spi_sclk <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    // released data line must not keep its last value
    spi_mosi <= ~spi_mosi;
  endtask : xfer
endmodule : rawc_host

// ---- testbench/rawc_clock_control_bench.sv ----
// self-checking bench for the clock control register block
`timescale 1ns/1ps
module rawc_clock_control_bench;
  logic core_clk, resetn, spi_cs_n, spi_sclk, spi_mosi, spi_miso, osc_slow_in, int_enable;
  logic [rawc_pkg::MIN_W-1:0] rtc_minutes, alarm_minutes;
  logic [rawc_pkg::HOUR_W-1:0] rtc_hours, alarm_hours;
  logic [15:0] wd_reload, rd;
  logic int_n, slow_pin, osc_run, bypass, wd_o, wd_oe_n;
  int num_errors, cmp_count, osc_cnt;

  rawc_clock_control uut (.core_clk(core_clk), .resetn(resetn), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .osc_slow_in(osc_slow_in),
    .rtc_minutes(rtc_minutes), .rtc_hours(rtc_hours), .alarm_minutes(alarm_minutes),
    .alarm_hours(alarm_hours), .int_enable(int_enable), .wd_reload(wd_reload), .int_n(int_n),
    .slow_clock_out_pin(slow_pin), .osc_run(osc_run), .crystal_bypass_select(bypass),
    .watchdog_out_n_o(wd_o), .watchdog_out_n_oe_n(wd_oe_n));
  rawc_host host (.core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // crystal stand-in, 40 core cycles per period to keep watchdog runs short
  always @(posedge core_clk) begin
    if (osc_cnt == 19) begin
      osc_cnt <= 0;
      osc_slow_in <= ~osc_slow_in;
    end else osc_cnt <= osc_cnt + 1;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wait_for(input string what, ref logic s, input logic v, input int lim);
    int i;
    i = 0;
    while (s !== v && i < lim) begin
      @(posedge core_clk);
      i++;
    end
    if (s !== v) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h after wait", what, v, s);
      tally_and_finish();
    end
  endtask : wait_for
  task automatic wr(input logic [15:0] v);
    host.xfer(rawc_pkg::OP_WR_CTRL, v, rd);
  endtask : wr
  task automatic rdreg(input logic [7:0] op);
    host.xfer(op, 16'h0000, rd);
  endtask : rdreg
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdreg(rawc_pkg::OP_RD_CTRL);
    chk("control after reset", rd, 16'h0000);
    chk("osc_run", osc_run, 16'h0001);
    chk("wd oe_n", wd_oe_n, 16'h0001);
    chk("slow pin", slow_pin, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_slow;
    wr(16'h0020);
    wait_for("osc high", osc_slow_in, 1'b1, 100);
    cyc(5);
    chk("slow pin high", slow_pin, 16'h0001);
    wait_for("osc low", osc_slow_in, 1'b0, 100);
    cyc(5);
    chk("slow pin low", slow_pin, 16'h0000);
    // reserved bits must not stick; stop bit halts the oscillator
    wr(16'hFF7C);
    cyc(2);
    chk("osc_run stopped", osc_run, 16'h0000);
    chk("bypass", bypass, 16'h0001);
    wait_for("osc high", osc_slow_in, 1'b1, 100);
    cyc(5);
    chk("slow pin halted", slow_pin, 16'h0000);
    rdreg(rawc_pkg::OP_RD_CTRL);
    chk("control readback", rd, 16'h007C);
    wr(16'h0000);
    cyc(2);
    chk("osc_run again", osc_run, 16'h0001);
    $display("test slow clock done");
  endtask : t_slow
  task automatic t_alarm;
    logic [1:0] sel [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h1};
    logic mv [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic ie [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic hit [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 7; k++) begin
      @(posedge core_clk);
      rtc_minutes <= mv[k] ? 7'h05 : 7'h04;
      rtc_hours <= mv[k] ? 6'h02 : 6'h03;
      int_enable <= ie[k];
      cyc(2);
      wr({12'h000, sel[k], 2'b00});
      cyc(2);
      chk("int_n idle", int_n, 16'h0001);
      if (mv[k]) rtc_hours <= 6'h03;
      else rtc_minutes <= 7'h05;
      cyc(4);
      chk("int_n on match", int_n, {15'h0000, ~(hit[k] & ie[k])});
      cyc(20);
      chk("int_n held", int_n, {15'h0000, ~(hit[k] & ie[k])});
      rdreg(rawc_pkg::OP_RD_STATUS);
      chk("status alarm flag", rd, hit[k] ? 16'h4000 : 16'h0000);
      cyc(3);
      chk("int_n released", int_n, 16'h0001);
      rdreg(rawc_pkg::OP_RD_STATUS);
      chk("status cleared", rd, 16'h0000);
    end
    int_enable <= 1'b1;
    $display("test alarm done");
  endtask : t_alarm
  task automatic t_wd;
    wr(16'h0001);
    chk("wd pin before expiry", wd_oe_n, 16'h0001);
    wait_for("wd pin low", wd_oe_n, 1'b0, 1000);
    chk("wd drive value", wd_o, 16'h0000);
    rdreg(rawc_pkg::OP_RD_CTRL);
    chk("expired flag", rd, 16'h0003);
    chk("wd pin still low", wd_oe_n, 16'h0000);
    // clear before the reloaded count runs out; the disable lands just after it expires again
    wr(16'h0001);
    cyc(2);
    chk("wd pin released", wd_oe_n, 16'h0001);
    wr(16'h0000);
    cyc(800);
    chk("wd pin disabled", wd_oe_n, 16'h0001);
    rdreg(rawc_pkg::OP_RD_CTRL);
    chk("control disabled", rd, 16'h0000);
    $display("test watchdog done");
  endtask : t_wd
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    osc_slow_in = 1'b0;
    int_enable = 1'b1;
    rtc_minutes = 7'h04;
    rtc_hours = 6'h03;
    alarm_minutes = 7'h05;
    alarm_hours = 6'h03;
    wd_reload = 16'h0008;
    num_errors = 0;
    cmp_count = 0;
    osc_cnt = 0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_slow();
    t_alarm();
    t_wd();
    tally_and_finish();
  end
endmodule : rawc_clock_control_bench
